//--- core/gpp_pkg.sv
/*
 * Shared constants for the general-purpose port pin block: register
 * offsets, bit positions, reset values and the external interrupt sense
 * encoding.
 * Assumes a byte-wide register port with a small address space.
 */
package gpp_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_OUTPUT = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_DIRECTION = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_INPUT = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h5;

   // Bit positions
   localparam int CTRL_PUD_BIT = 0;
   localparam int STAT_EXT_BIT = 0;
   localparam int STAT_WAKE_BIT = 1;
   localparam int STAT_W = 2;

   // Reset values
   localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
   localparam logic [STAT_W-1:0] RST_STAT = 2'h0;

   // External interrupt sense codes
   typedef enum logic [1:0] {
      GPP_SENSE_LOW = 2'b00,
      GPP_SENSE_ANY = 2'b01,
      GPP_SENSE_FALL = 2'b10,
      GPP_SENSE_RISE = 2'b11
   } gpp_sense_t;

endpackage

//--- core/gpp_pin_sync.sv
/*
 * Two-stage input synchroniser for one pin.
 * Assumes the pin level is already clamped as sleep requires; the first
 * stage stands in for a latch open while clk is high, so it captures the
 * level present at the falling edge.
 */
`timescale 1ns/100ps
`default_nettype none

module gpp_pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Data
   input wire logic din,
   output logic dout
);

   logic hold_reg;
   logic hold_next;
   logic sample_reg;
   logic sample_next;

   always_comb begin
      hold_next = ce ? din : hold_reg;
      sample_next = ce ? hold_reg : sample_reg;
   end

   // Value held when the clock falls
   always_ff @(negedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_reg <= 1'b0;
      end else begin
         hold_reg <= hold_next;
      end
   end

   // Held value loaded on the next rising edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sample_reg <= 1'b0;
      end else begin
         sample_reg <= sample_next;
      end
   end

   assign dout = sample_reg;

endmodule

`default_nettype wire

//--- core/gpp_port.sv
/*
 * One bidirectional general-purpose port: per-pin direction, output and
 * pull-up control, input synchronisers, deep-sleep input clamp, external
 * interrupt flag and a small register port for software.
 * Assumes the sleep controller, the interrupt controller and alternate
 * functions drive their control inputs synchronously to clk.
 */
// Summary of operation
// - Direction 0, output 1, pull-up disable 0: input with pull-up on.
// - Global pull-up disable turns off every pull-up; such pins float.
// - Direction 1 drives the pin to the output bit, ignoring pull-up disable.
// - Pin level readable in the input bit for any direction, via synchroniser.
// - Latch open while clock high, holds at fall, loads register on rise.
// - External transition reaches input bit after half to one and a half periods.
// - A software-written output value reaches the input bit after one period.
// - Deep sleep clamps each digital input to ground before the buffer.
// - Clamp bypassed for enabled external interrupt pins and alternate functions.
// - High interrupt pin sensing any change or a rising edge sets its flag when the clamp releases.
// - Inputs stay unclamped while deep sleep is low (active, idle); reset does not lift the clamp.
// - All pull-ups disabled while reset is active.
// - Writing one to an input bit inverts the matching output bit.
`timescale 1ns/100ps
`default_nettype none

module gpp_port
   import gpp_pkg::*;
#(
   parameter int NPINS = 6,
   parameter int INT_PIN = 1
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Pads
   input wire logic [NPINS-1:0] pad_in,
   output logic [NPINS-1:0] pad_out,
   output logic [NPINS-1:0] pad_oe,
   output logic [NPINS-1:0] pad_pullup,
   // System control
   input wire logic deep_sleep,
   input wire logic ext_int_enable,
   input wire logic [1:0] ext_int_sense,
   input wire logic [NPINS-1:0] alt_input_override,
   // Interrupt
   output logic irq
);

   logic [NPINS-1:0] out_reg;
   logic [NPINS-1:0] out_next;
   logic [NPINS-1:0] dir_reg;
   logic [NPINS-1:0] dir_next;
   logic pud_reg;
   logic pud_next;
   logic [STAT_W-1:0] stat_reg;
   logic [STAT_W-1:0] stat_next;
   logic [STAT_W-1:0] mask_reg;
   logic [STAT_W-1:0] mask_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [NPINS-1:0] pad_out_reg;
   logic [NPINS-1:0] pad_out_next;
   logic [NPINS-1:0] pad_oe_reg;
   logic [NPINS-1:0] pad_oe_next;
   logic [NPINS-1:0] pullup_reg;
   logic [NPINS-1:0] pullup_next;
   logic irq_reg;
   logic irq_next;
   logic int_prev_reg;
   logic int_prev_next;
   logic clamp_prev_reg;
   logic clamp_prev_next;

   logic [NPINS-1:0] clamp;
   logic [NPINS-1:0] din_gated;
   logic [NPINS-1:0] pin_sample;
   logic [DATA_W-1:0] wdata_pins;
   logic wr_output;
   logic wr_direction;
   logic wr_toggle;
   logic wr_control;
   logic wr_stat;
   logic wr_mask;
   logic int_now;
   logic int_edge;
   logic wake_event;
   logic [STAT_W-1:0] events;

   // Input clamp and synchroniser per pin
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_pin
         // Interrupt pin escapes the clamp while its request is enabled or its alternate function overrides
         if (gi == INT_PIN) begin : g_int
            assign clamp[gi] = deep_sleep && !alt_input_override[gi]
                               && !ext_int_enable;
         end else begin : g_plain
            assign clamp[gi] = deep_sleep && !alt_input_override[gi];
         end
         assign din_gated[gi] = clamp[gi] ? 1'b0 : pad_in[gi];

         gpp_pin_sync u_sync (
            .clk(clk),
            .rstn(rstn),
            .ce(ce),
            .din(din_gated[gi]),
            .dout(pin_sample[gi])
         );
      end
   endgenerate

   assign wdata_pins = reg_wdata;

   // Address decode
   always_comb begin
      wr_output = 1'b0;
      wr_direction = 1'b0;
      wr_toggle = 1'b0;
      wr_control = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (reg_wr && reg_addr == OFS_OUTPUT) begin
         wr_output = 1'b1;
      end else if (reg_wr && reg_addr == OFS_DIRECTION) begin
         wr_direction = 1'b1;
      end else if (reg_wr && reg_addr == OFS_INPUT) begin
         wr_toggle = 1'b1;
      end else if (reg_wr && reg_addr == OFS_CONTROL) begin
         wr_control = 1'b1;
      end else if (reg_wr && reg_addr == OFS_IRQ_STATUS) begin
         wr_stat = 1'b1;
      end else if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
         wr_mask = 1'b1;
      end
   end

   // Software-visible control state
   always_comb begin
      out_next = out_reg;
      dir_next = dir_reg;
      pud_next = pud_reg;
      mask_next = mask_reg;
      if (wr_output) begin
         out_next = wdata_pins[NPINS-1:0];
      end else if (wr_toggle) begin
         out_next = out_reg ^ wdata_pins[NPINS-1:0];
      end
      if (wr_direction) begin
         dir_next = wdata_pins[NPINS-1:0];
      end
      if (wr_control) begin
         pud_next = reg_wdata[CTRL_PUD_BIT];
      end
      if (wr_mask) begin
         mask_next = reg_wdata[STAT_W-1:0];
      end
   end

   // Pad drive: flip-flops load the next control values, so outputs change on the same edge as control
   always_comb begin
      pad_out_next = out_next;
      pad_oe_next = dir_next;
      pullup_next = ~dir_next & out_next & {NPINS{~pud_next}};
   end

   // External interrupt edge detection; the clamp release makes a rising
   // edge on a high pin, which is how an unenabled pin gets its flag
   always_comb begin
      int_now = pin_sample[INT_PIN];
      int_prev_next = int_now;
      clamp_prev_next = clamp[INT_PIN];
      int_edge = 1'b0;
      case (ext_int_sense)
         GPP_SENSE_ANY: int_edge = int_now != int_prev_reg;
         GPP_SENSE_FALL: int_edge = !int_now && int_prev_reg;
         GPP_SENSE_RISE: int_edge = int_now && !int_prev_reg;
         default: int_edge = 1'b0;
      endcase
      // Release of the clamp on the interrupt pin itself
      wake_event = clamp_prev_reg && !clamp[INT_PIN];
   end

   // Sticky status: a new event wins over a same-cycle clear
   always_comb begin
      events = '0;
      events[STAT_EXT_BIT] = int_edge;
      events[STAT_WAKE_BIT] = wake_event;
      stat_next = stat_reg;
      if (wr_stat) begin
         stat_next = stat_reg & ~reg_wdata[STAT_W-1:0];
      end
      // Level sense keeps the flag clear
      if (ext_int_sense == GPP_SENSE_LOW) begin
         stat_next[STAT_EXT_BIT] = 1'b0;
      end
      stat_next = stat_next | events;
      irq_next = |(stat_next & mask_next);
   end

   // Read data, valid in the cycle after the strobe only
   always_comb begin
      rdata_next = RST_DATA;
      if (reg_rd) begin
         if (reg_addr == OFS_OUTPUT) begin
            rdata_next[NPINS-1:0] = out_reg;
         end else if (reg_addr == OFS_DIRECTION) begin
            rdata_next[NPINS-1:0] = dir_reg;
         end else if (reg_addr == OFS_INPUT) begin
            rdata_next[NPINS-1:0] = pin_sample;
         end else if (reg_addr == OFS_CONTROL) begin
            rdata_next[CTRL_PUD_BIT] = pud_reg;
         end else if (reg_addr == OFS_IRQ_STATUS) begin
            rdata_next[STAT_W-1:0] = stat_reg;
         end else if (reg_addr == OFS_IRQ_MASK) begin
            rdata_next[STAT_W-1:0] = mask_reg;
         end
      end
   end

   // Reset clears every pull-up and output enable at once, without clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_reg <= '0;
         dir_reg <= '0;
         pud_reg <= 1'b0;
         stat_reg <= RST_STAT;
         mask_reg <= RST_STAT;
         rdata_reg <= RST_DATA;
         pad_out_reg <= '0;
         pad_oe_reg <= '0;
         pullup_reg <= '0;
         irq_reg <= 1'b0;
         int_prev_reg <= 1'b0;
         clamp_prev_reg <= 1'b0;
      end else if (ce) begin
         out_reg <= out_next;
         dir_reg <= dir_next;
         pud_reg <= pud_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         rdata_reg <= rdata_next;
         pad_out_reg <= pad_out_next;
         pad_oe_reg <= pad_oe_next;
         pullup_reg <= pullup_next;
         irq_reg <= irq_next;
         int_prev_reg <= int_prev_next;
         clamp_prev_reg <= clamp_prev_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign pad_out = pad_out_reg;
   assign pad_oe = pad_oe_reg;
   assign pad_pullup = pullup_reg;
   assign irq = irq_reg;

endmodule

`default_nettype wire

//--- verif/gpp_port_properties.sv
/*
 * Port-level checker for the port pin block, bound onto gpp_port.
 * Assumes no input read is made within two cycles of reset release or of ce low.
 */
`timescale 1ns/100ps
`default_nettype none
module gpp_port_chk
   import gpp_pkg::*;
#(parameter int NPINS = 6, parameter int INT_PIN = 1) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Pads
   input wire logic [NPINS-1:0] pad_in,
   input wire logic [NPINS-1:0] pad_out,
   input wire logic [NPINS-1:0] pad_oe,
   input wire logic [NPINS-1:0] pad_pullup,
   // System control and interrupt
   input wire logic deep_sleep,
   input wire logic ext_int_enable,
   input wire logic [1:0] ext_int_sense,
   input wire logic [NPINS-1:0] alt_input_override,
   input wire logic irq
);
   // Pins whose digital input survives deep sleep
   wire logic [NPINS-1:0] keep = alt_input_override | (NPINS'(ext_int_enable) << INT_PIN);
   wire logic rd_in = ce && reg_rd && reg_addr == OFS_INPUT;
   wire logic wr_ok = ce && reg_wr;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   reset_quiet_a: assert property ($rose(rstn) |-> pad_oe == '0 && pad_pullup == '0 && !irq)
      else $error("pads not quiet after reset");
   pullup_mode_a: assert property ((pad_pullup & (pad_oe | ~pad_out)) == '0)
      else $error("pull-up on outside input-high mode");
   out_write_a: assert property (wr_ok && reg_addr == OFS_OUTPUT |=> pad_out == $past(reg_wdata[NPINS-1:0]))
      else $error("drive value differs from write");
   dir_write_a: assert property (wr_ok && reg_addr == OFS_DIRECTION |=> pad_oe == $past(reg_wdata[NPINS-1:0]))
      else $error("drive enable differs from write");
   toggle_out_a: assert property (wr_ok && reg_addr == OFS_INPUT |=> pad_out == ($past(pad_out) ^ $past(reg_wdata[NPINS-1:0])))
      else $error("input write did not toggle output");
   sync_read_a: assert property (rd_in && !$past(deep_sleep) |=> reg_rdata == DATA_W'($past(pad_in, 2)))
      else $error("input read not two-stage synced pad");
   clamp_read_a: assert property (rd_in && $past(deep_sleep) |=> (reg_rdata[NPINS-1:0] & ~$past(keep, 2)) == '0)
      else $error("clamped pin read nonzero");
   rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata == '0)
      else $error("read data outside read cycle");
endmodule
bind gpp_port gpp_port_chk #(.NPINS(NPINS), .INT_PIN(INT_PIN)) i_gpp_port_chk (
   .clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
   .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .deep_sleep(deep_sleep),
   .ext_int_enable(ext_int_enable), .ext_int_sense(ext_int_sense),
   .alt_input_override(alt_input_override), .irq(irq));
`default_nettype wire

//--- verif/gpp_board.sv
/*
 * Board model: resolves each pad from port drive, external drivers and pull-up.
 * Assumes the bench never drives a pin externally while the port drives it.
 */
`timescale 1ns/100ps
`default_nettype none
module gpp_board #(parameter int NPINS = 6) (
   // Clock
   input wire logic clk,
   // Port side
   input wire logic [NPINS-1:0] pad_out,
   input wire logic [NPINS-1:0] pad_oe,
   input wire logic [NPINS-1:0] pad_pullup,
   // External drivers
   input wire logic [NPINS-1:0] ext_en,
   input wire logic [NPINS-1:0] ext_val,
   output logic [NPINS-1:0] pad_in
);
   // Floating pins wander so a stale level never passes for a match
   logic [NPINS-1:0] float_reg = '0;
   always @(posedge clk) float_reg <= ~float_reg;
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (ext_en[i]) pad_in[i] = ext_val[i];
         else if (pad_pullup[i]) pad_in[i] = 1'b1;
         else pad_in[i] = float_reg[i];
      end
   end
endmodule
`default_nettype wire

//--- verif/tb.sv
/*
 * Self-checking bench for the port pin block: register tasks and scenarios.
 * Assumes the board model and the bound checker are compiled beside gpp_port.
 */
`timescale 1ns/100ps
`default_nettype none
module tb
   import gpp_pkg::*;
;
   localparam int NPINS = 6;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ce = 1'b1;
   logic deep_sleep = 1'b0;
   logic ext_int_enable = 1'b0;
   logic [1:0] ext_int_sense = 2'b00;
   logic [NPINS-1:0] alt_input_override = '0;
   logic [NPINS-1:0] ext_en = '0;
   logic [NPINS-1:0] ext_val = '0;
   wire logic [DATA_W-1:0] reg_rdata;
   wire logic [NPINS-1:0] pad_in, pad_out, pad_oe, pad_pullup;
   wire logic irq;
   int failures = 0;
   int n_checks = 0;
   always #4 clk = ~clk;
   gpp_port #(.NPINS(NPINS), .INT_PIN(1)) i_gpp_port (.clk(clk), .rstn(rstn), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup(pad_pullup), .deep_sleep(deep_sleep), .ext_int_enable(ext_int_enable),
      .ext_int_sense(ext_int_sense), .alt_input_override(alt_input_override), .irq(irq));
   gpp_board #(.NPINS(NPINS)) i_gpp_board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
   task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string name,
                     input logic [DATA_W-1:0] m = 8'hff);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(name, exp, reg_rdata & m);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Run takes about a hundred and twenty cycles
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      idle(3);
      chk("pad_pullup", 8'h00, DATA_W'(pad_pullup));
      rd(OFS_OUTPUT, RST_DATA, "output");
      rd(OFS_DIRECTION, RST_DATA, "direction");
      // Output first, so high pins pass through the pulled-up state
      wr(OFS_OUTPUT, 8'h33);
      wr(OFS_DIRECTION, 8'h0f);
      chk("pad_pullup", 8'h30, DATA_W'(pad_pullup));
      chk("pad_oe", 8'h0f, DATA_W'(pad_oe));
      chk("pad_out", 8'h33, DATA_W'(pad_out));
      rd(OFS_INPUT, 8'h33, "input");
      wr(OFS_CONTROL, 8'h01);
      chk("pad_pullup", 8'h00, DATA_W'(pad_pullup));
      chk("pad_out", 8'h33, DATA_W'(pad_out));
      @(posedge clk);
      ext_en <= 6'h30;
      ext_val <= 6'h20;
      rd(OFS_INPUT, 8'h23, "input");
      wr(OFS_INPUT, 8'h11);
      chk("pad_out", 8'h22, DATA_W'(pad_out));
      rd(OFS_INPUT, 8'h22, "input");
      wr(3'h6, 8'hff);
      rd(3'h6, 8'h00, "unmapped");
      rd(OFS_OUTPUT, 8'h22, "output");
      // Low clock enable must swallow a write; pads stay driven meanwhile
      @(posedge clk);
      ce <= 1'b0;
      wr(OFS_OUTPUT, 8'h0f);
      chk("pad_out frozen", 8'h22, DATA_W'(pad_out));
      @(posedge clk);
      ce <= 1'b1;
      idle(2);
      rd(OFS_OUTPUT, 8'h22, "output");
      @(posedge clk);
      alt_input_override <= 6'h20;
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         ext_int_sense <= 2'(s);
         wr(OFS_IRQ_STATUS, 8'h03);
         @(posedge clk);
         deep_sleep <= 1'b1;
         idle(3);
         rd(OFS_INPUT, 8'h20, "sleep input");
         @(posedge clk);
         deep_sleep <= 1'b0;
         idle(3);
         rd(OFS_INPUT, 8'h22, "awake input");
         // Bit 1 marks the clamp release on the interrupt pin in every mode
         rd(OFS_IRQ_STATUS, {6'h00, 1'b1, s != 0}, "irq status");
         chk("irq masked", 8'h00, DATA_W'(irq));
      end
      wr(OFS_IRQ_MASK, 8'h01);
      idle(2);
      chk("irq", 8'h01, DATA_W'(irq));
      wr(OFS_IRQ_STATUS, 8'h03);
      idle(2);
      chk("irq", 8'h00, DATA_W'(irq));
      rd(OFS_IRQ_STATUS, 8'h00, "irq status");
      @(posedge clk);
      ext_int_enable <= 1'b1;
      deep_sleep <= 1'b1;
      idle(3);
      rd(OFS_INPUT, 8'h22, "int pin input");
      finish_test();
   end
endmodule
`default_nettype wire
